// [hdl/rwc_top.sv]
// chip reset sequencer with supervision timers, traps and clock factor control
`timescale 1ns/1ps
module rwc_top
  import rwc_pkg::*;
#(
  parameter int unsigned TICK_CYCLES  = TICK_CYC,
  parameter int unsigned PULSE_CYCLES = PULSE_CYC,
  parameter int unsigned TRAP_W       = 4
) (
  input  wire logic                  mclk,
  input  wire logic                  srst,
  input  wire logic                  reset_line_n_i,
  output logic                       reset_line_n_o,
  output logic                       reset_line_n_oe,
  input  wire logic                  low_voltage_detector,
  input  wire logic [NUM_TIMERS-1:0] timer_service,
  input  wire logic                  sw_reset_req,
  input  wire logic                  trap_req,
  input  wire logic [TRAP_W-1:0]     trap_code,
  input  wire logic                  trap_reset_needed,
  input  wire logic                  service_drive,
  input  wire logic [2:0]            clk_factor,
  output logic                       osc_run,
  output logic                       core_halt,
  output logic                       core_run,
  output logic                       boot_start,
  output logic [15:0]                boot_addr,
  output logic                       io_hiz,
  output logic                       mem_hiz,
  output logic                       service_line_n_oe,
  output logic                       service_pullup_en,
  output logic [2:0]                 reset_cause,
  output logic                       trap_irq,
  output logic [TRAP_W-1:0]          trap_log_code,
  output logic                       trap_log_valid,
  output logic [NUM_TIMERS-1:0]      timer_expired,
  output logic                       pll_enable,
  output logic [3:0]                 pll_mult,
  output logic                       app_half,
  output logic                       app_slot
);

  localparam int unsigned DLY_MAX = (PULSE_CYCLES > WAKE_CYC) ? PULSE_CYCLES : WAKE_CYC;
  localparam int unsigned DLY_W   = $clog2(DLY_MAX + 1);
  localparam int unsigned TICK_W  = $clog2(TICK_CYCLES + 1);
  localparam logic [DLY_W-1:0]  PULSE_LAST = DLY_W'(PULSE_CYCLES - 1);
  localparam logic [DLY_W-1:0]  WAKE_LAST  = DLY_W'(WAKE_CYC - 1);
  localparam logic [TICK_W-1:0] TICK_LAST  = TICK_W'(TICK_CYCLES - 1);

  // refuse counts the sequencer cannot serve; the pulse check below needs 8 low cycles
  if (PULSE_CYCLES < 8 || TICK_CYCLES < 2 || TRAP_W < 1) begin : g_bad_param
    $error("rwc_top: pulse, tick or trap width parameter out of range");
  end

  rwc_state_t state_q;
  rwc_state_t state_d;
  logic [DLY_W-1:0]      dly_q;
  logic [TICK_W-1:0]     tick_cnt_q;
  logic                  tick_q;
  logic [NUM_TIMERS-1:0] expire;
  logic                  exp_any;
  logic                  line_low;
  logic                  trap_rst;
  logic [2:0]            cause_d;
  logic [2:0]            cause_q;
  logic                  line_oe_q;
  logic                  halt_q;
  logic                  run_q;
  logic                  boot_q;
  logic [15:0]           boot_addr_q;
  logic                  osc_q;
  logic                  pins_hiz_q;
  logic                  svc_oe_q;
  logic                  svc_pu_q;
  logic                  trap_irq_q;
  logic [TRAP_W-1:0]     trap_code_q;
  logic                  trap_valid_q;

  assign line_low = ~reset_line_n_i;
  assign exp_any  = |expire;
  assign trap_rst = trap_req & trap_reset_needed;

  always_ff @(posedge mclk) begin
    if (srst) begin
      tick_cnt_q <= '0;
      tick_q     <= 1'b0;
    end else begin
      tick_q     <= (tick_cnt_q == TICK_LAST);
      tick_cnt_q <= (tick_cnt_q == TICK_LAST) ? '0 : TICK_W'(tick_cnt_q + 1'b1);
    end
  end

  for (genvar gi = 0; gi < NUM_TIMERS; gi++) begin : g_timer
    rwc_sup_timer u_timer (
      .mclk    (mclk),
      .srst    (srst),
      .tick    (tick_q),
      .service (timer_service[gi]),
      .hold    (halt_q),
      .expire  (expire[gi])
    );
  end

  // clock factor and pacing
  rwc_clk_sel u_clk (
    .mclk       (mclk),
    .srst       (srst),
    .clk_factor (clk_factor),
    .pll_enable (pll_enable),
    .pll_mult   (pll_mult),
    .app_half   (app_half),
    .app_slot   (app_slot)
  );

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_HOLD: begin
        if (!low_voltage_detector && !line_low) state_d = ST_WAKE;
      end
      ST_WAKE: begin
        if (low_voltage_detector || line_low) state_d = ST_HOLD;
        else if (dly_q == WAKE_LAST) state_d = ST_RUN;
      end
      ST_RUN: begin
        if (low_voltage_detector) state_d = ST_HOLD;
        else if (trap_rst || exp_any || sw_reset_req) state_d = ST_PULSE;
        else if (line_low) state_d = ST_HOLD;
      end
      ST_PULSE: begin
        if (low_voltage_detector) state_d = ST_HOLD;
        else if (dly_q == PULSE_LAST) state_d = ST_HOLD;
      end
      default: state_d = ST_HOLD;
    endcase
  end

  always_comb begin
    cause_d = cause_q;
    if (low_voltage_detector) cause_d = CAUSE_POR_LVD;
    else if (state_q == ST_RUN && trap_rst) cause_d = CAUSE_TRAP;
    else if (state_q == ST_RUN && exp_any) cause_d = CAUSE_TIMER;
    else if (state_q == ST_RUN && sw_reset_req) cause_d = CAUSE_SW;
    else if ((state_q == ST_RUN || state_q == ST_WAKE) && line_low) cause_d = CAUSE_EXT;
  end

  // state and cause registers, power-up counts as the low-voltage source
  always_ff @(posedge mclk) begin
    if (srst) begin
      state_q <= ST_HOLD;
      cause_q <= CAUSE_POR_LVD;
    end else begin
      state_q <= state_d;
      cause_q <= cause_d;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      dly_q <= '0;
    end else begin
      dly_q <= (state_d != state_q) ? '0 : DLY_W'(dly_q + 1'b1);
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      line_oe_q <= 1'b1;
    end else begin
      line_oe_q <= (state_d == ST_PULSE) | low_voltage_detector;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      halt_q     <= 1'b1;
      pins_hiz_q <= 1'b1;
      svc_oe_q   <= 1'b0;
      svc_pu_q   <= 1'b1;
      osc_q      <= 1'b1;
    end else begin
      halt_q     <= (state_d != ST_RUN);
      pins_hiz_q <= (state_d != ST_RUN);
      svc_oe_q   <= (state_d == ST_RUN) & service_drive;
      svc_pu_q   <= (state_d != ST_RUN);
      osc_q      <= 1'b1; // oscillator never stops
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      boot_q      <= 1'b0;
      boot_addr_q <= BOOT_ADDR;
      run_q       <= 1'b0;
    end else begin
      boot_q      <= (state_q == ST_HOLD) && (state_d == ST_WAKE);
      boot_addr_q <= BOOT_ADDR;
      run_q       <= (state_d == ST_RUN);
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      trap_irq_q   <= 1'b0;
      trap_code_q  <= '0;
      trap_valid_q <= 1'b0;
    end else begin
      trap_irq_q <= trap_req & (state_q == ST_RUN);
      if (trap_req && state_q == ST_RUN) begin
        trap_code_q  <= trap_code;
        trap_valid_q <= 1'b1;
      end
    end
  end

  // timer expiry flags for diagnostics, gathered while running and cleared only by srst
  logic [NUM_TIMERS-1:0] exp_seen_q;
  always_ff @(posedge mclk) begin
    if (srst) begin
      exp_seen_q <= '0;
    end else if (state_q == ST_RUN) begin
      exp_seen_q <= exp_seen_q | expire;
    end
  end

  assign reset_line_n_o    = 1'b0;
  assign reset_line_n_oe   = line_oe_q;
  assign osc_run           = osc_q;
  assign core_halt         = halt_q;
  assign core_run          = run_q;
  assign boot_start        = boot_q;
  assign boot_addr         = boot_addr_q;
  assign io_hiz            = pins_hiz_q;
  assign mem_hiz           = pins_hiz_q;
  assign service_line_n_oe = svc_oe_q;
  assign service_pullup_en = svc_pu_q;
  assign reset_cause       = cause_q;
  assign trap_irq          = trap_irq_q;
  assign trap_log_code     = trap_code_q;
  assign trap_log_valid    = trap_valid_q;
  assign timer_expired     = exp_seen_q;

  default clocking cb_main @(posedge mclk); endclocking
  default disable iff (srst);

  sequence s_sw_drop;
    state_q == ST_RUN && sw_reset_req && !low_voltage_detector;
  endsequence

  sequence s_line_driven;
    line_oe_q && !reset_line_n_o;
  endsequence

  AST_SW_PULSE: assert property (s_sw_drop |=> s_line_driven [*8])
    else $error("software reset did not drive the line low");

  AST_PULSE_LEN: assert property (
    state_q == ST_PULSE && state_d == ST_HOLD && !low_voltage_detector |-> dly_q == PULSE_LAST)
    else $error("reset pulse ended at the wrong length");

  AST_WAKE_RUN: assert property (
    state_q == ST_WAKE && state_d == ST_RUN |-> dly_q == WAKE_LAST ##1 run_q && !halt_q)
    else $error("core started at the wrong delay");

  AST_HALT: assert property (line_low |=> halt_q)
    else $error("core not halted while line low");

  AST_SAFE_PINS: assert property (halt_q |-> pins_hiz_q && !svc_oe_q && svc_pu_q && osc_q)
    else $error("pins not in safe state during reset");

  AST_BOOT: assert property (boot_q |-> state_q == ST_WAKE && boot_addr_q == BOOT_ADDR)
    else $error("boot start without release or wrong address");

  AST_LVD: assert property (low_voltage_detector |=> line_oe_q && cause_q == CAUSE_POR_LVD)
    else $error("low voltage did not hold the line");

  AST_TIMER_CAUSE: assert property (
    state_q == ST_RUN && exp_any && !low_voltage_detector && !trap_rst
    |=> cause_q == CAUSE_TIMER && state_q == ST_PULSE)
    else $error("timer expiry not recorded");

  AST_TRAP: assert property (state_q == ST_RUN && trap_req |=> trap_irq_q && trap_valid_q)
    else $error("trap not raised");

endmodule

// [hdl/rwc_pkg.sv]
// shared constants and types for the reset, supervision and clock control block
package rwc_pkg;

  // reference clock of the logic and derived cycle counts
  localparam int unsigned CLK_HZ        = 100_000_000;
  localparam int unsigned CYC_PER_MS    = CLK_HZ / 1000;
  localparam int unsigned CYC_PER_US    = CLK_HZ / 1_000_000;

  // supervision timer tick period
  localparam int unsigned TICK_MS       = 840;
  localparam int unsigned TICK_CYC      = TICK_MS * CYC_PER_MS;

  // reset line pulse for timer expiry, software reset and traps
  localparam int unsigned PULSE_US      = 100;
  localparam int unsigned PULSE_CYC     = PULSE_US * CYC_PER_US;

  // delay from line release to core start
  localparam int unsigned WAKE_US       = 10;
  localparam int unsigned WAKE_CYC      = WAKE_US * CYC_PER_US;

  // number of supervised processors
  localparam int unsigned NUM_TIMERS    = 3;

  // first fetch address after release
  localparam logic [15:0] BOOT_ADDR     = 16'h0001;

  // clock factor selection codes
  localparam logic [2:0]  FAC_HALF      = 3'h0;
  localparam logic [2:0]  FAC_X1        = 3'h1;
  localparam logic [2:0]  FAC_X2        = 3'h2;
  localparam logic [2:0]  FAC_X4        = 3'h3;
  localparam logic [2:0]  FAC_X8        = 3'h4;

  // hardware multiplier values applied to the 100 MHz reference
  localparam logic [3:0]  MULT_1        = 4'h1;
  localparam logic [3:0]  MULT_2        = 4'h2;
  localparam logic [3:0]  MULT_4        = 4'h4;
  localparam logic [3:0]  MULT_8        = 4'h8;

  // reset cause encodings
  localparam logic [2:0]  CAUSE_NONE    = 3'h0;
  localparam logic [2:0]  CAUSE_POR_LVD = 3'h1;
  localparam logic [2:0]  CAUSE_EXT     = 3'h2;
  localparam logic [2:0]  CAUSE_TIMER   = 3'h3;
  localparam logic [2:0]  CAUSE_SW      = 3'h4;
  localparam logic [2:0]  CAUSE_TRAP    = 3'h5;

  // reset sequencer states, gray along hold, wake, run, pulse
  typedef enum logic [1:0] {
    ST_HOLD  = 2'h0,
    ST_WAKE  = 2'h1,
    ST_RUN   = 2'h3,
    ST_PULSE = 2'h2
  } rwc_state_t;

endpackage

// [hdl/rwc_sup_timer.sv]
// one free-running supervision timer fed by a shared tick
`timescale 1ns/1ps
module rwc_sup_timer
  import rwc_pkg::*;
(
  input  wire logic mclk,
  input  wire logic srst,
  input  wire logic tick,
  input  wire logic service,
  input  wire logic hold,
  output logic      expire
);

  logic serviced_q;
  logic expire_q;
  logic svc_now;

  // a halted processor cannot service, so it is treated as serviced
  assign svc_now = service | hold;

  always_ff @(posedge mclk) begin
    if (srst) begin
      serviced_q <= 1'b0;
    end else if (tick) begin
      serviced_q <= svc_now; // service in the tick cycle carries to the next tick
    end else if (svc_now) begin
      serviced_q <= 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      expire_q <= 1'b0;
    end else begin
      expire_q <= tick & ~serviced_q & ~svc_now;
    end
  end

  assign expire = expire_q;

  AST_EXPIRE: assert property (@(posedge mclk) disable iff (srst)
    tick && !serviced_q && !svc_now |=> expire_q)
    else $error("timer did not expire on an unserviced tick");

  AST_NO_EXPIRE: assert property (@(posedge mclk) disable iff (srst)
    (!tick || serviced_q || svc_now) |=> !expire_q)
    else $error("timer expired without an unserviced tick");

endmodule

// [hdl/rwc_clk_sel.sv]
// system clock factor selection and application pacing
`timescale 1ns/1ps
module rwc_clk_sel
  import rwc_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       srst,
  input  wire logic [2:0] clk_factor,
  output logic            pll_enable,
  output logic [3:0]      pll_mult,
  output logic            app_half,
  output logic            app_slot
);

  logic [3:0] mult_q;
  logic       pll_q;
  logic       half_q;
  logic       slot_q;

  always_ff @(posedge mclk) begin
    if (srst) begin
      mult_q <= MULT_1;
    end else begin
      case (clk_factor)
        FAC_X2:  mult_q <= MULT_2;
        FAC_X4:  mult_q <= MULT_4;
        FAC_X8:  mult_q <= MULT_8;
        default: mult_q <= MULT_1; // half, x1 and unknown codes run at the reference rate
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      pll_q <= 1'b0;
    end else begin
      pll_q <= (clk_factor == FAC_X2) | (clk_factor == FAC_X4) | (clk_factor == FAC_X8);
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      half_q <= 1'b0;
      slot_q <= 1'b1;
    end else begin
      half_q <= (clk_factor == FAC_HALF);
      slot_q <= (clk_factor == FAC_HALF) ? ~slot_q : 1'b1; // every other cycle at half
    end
  end

  assign pll_mult   = mult_q;
  assign pll_enable = pll_q;
  assign app_half   = half_q;
  assign app_slot   = slot_q;

  AST_PLL: assert property (@(posedge mclk) disable iff (srst)
    pll_q == (mult_q != MULT_1))
    else $error("pll enable disagrees with multiplier");

  AST_HALF_SLOT: assert property (@(posedge mclk) disable iff (srst)
    half_q && $past(half_q) |-> mult_q == MULT_1 && slot_q != $past(slot_q))
    else $error("half factor must run at x1 with alternating slots");

endmodule

// [sim/rwc_ext_switch.sv]
// open-drain external reset switch model on the far side of the reset wire
`timescale 1ns/1ps
module rwc_ext_switch #(
  parameter int unsigned HOLD_CYC = 30
) (
  input  wire logic mclk,
  input  wire logic press,
  output logic      pull_oe
);
  int unsigned cnt_q = 0;

  // open-drain pull only
  // pulls the wire low for a while, never drives it high; the pull-up restores it
  always_ff @(posedge mclk) begin
    if (press) begin
      cnt_q <= HOLD_CYC;
    end else if (cnt_q != 0) begin
      cnt_q <= cnt_q - 1;
    end
  end
  assign pull_oe = (cnt_q != 0);
endmodule

// [sim/tb.sv]
// self-checking bench for the reset sequencer block
`timescale 1ns/1ps
module tb;
  import rwc_pkg::*;
  localparam int unsigned TICK  = 200;
  localparam int unsigned PULSE = 20;
  localparam int unsigned LIMIT = 30000;

  logic                  mclk                 = 1'b0;
  logic                  srst                 = 1'b1;
  logic                  low_voltage_detector = 1'b0;
  logic [NUM_TIMERS-1:0] timer_service        = 3'h0;
  logic [NUM_TIMERS-1:0] svc_en               = 3'h7;
  logic                  sw_reset_req         = 1'b0;
  logic                  trap_req             = 1'b0;
  logic [3:0]            trap_code            = 4'h0;
  logic                  trap_reset_needed    = 1'b0;
  logic                  service_drive        = 1'b0;
  logic [2:0]            clk_factor           = 3'h1;
  logic                  press                = 1'b0;
  logic                  ext_pull;
  logic                  line_n;
  logic                  reset_line_n_o, reset_line_n_oe, osc_run, core_halt, core_run, boot_start;
  logic                  io_hiz, mem_hiz, service_line_n_oe, service_pullup_en, trap_irq, trap_log_valid;
  logic                  pll_enable, app_half, app_slot;
  logic [15:0]           boot_addr;
  logic [2:0]            reset_cause;
  logic [3:0]            trap_log_code;
  logic [3:0]            pll_mult;
  logic [NUM_TIMERS-1:0] timer_expired;
  int unsigned           cyc_cnt              = 0;
  int                    n_mismatch           = 0;
  int                    checks_done          = 0;

  // wire level: low if any party pulls, otherwise the pull-up wins
  assign line_n = ((reset_line_n_oe && !reset_line_n_o) || ext_pull) ? 1'b0 : 1'b1;

  rwc_top #(.TICK_CYCLES(TICK), .PULSE_CYCLES(PULSE), .TRAP_W(4)) dut_u (
    .mclk, .srst, .reset_line_n_i(line_n), .reset_line_n_o, .reset_line_n_oe,
    .low_voltage_detector, .timer_service, .sw_reset_req, .trap_req, .trap_code,
    .trap_reset_needed, .service_drive, .clk_factor, .osc_run, .core_halt, .core_run,
    .boot_start, .boot_addr, .io_hiz, .mem_hiz, .service_line_n_oe, .service_pullup_en,
    .reset_cause, .trap_irq, .trap_log_code, .trap_log_valid, .timer_expired,
    .pll_enable, .pll_mult, .app_half, .app_slot
  );

  rwc_ext_switch #(.HOLD_CYC(30)) ext_u (.mclk(mclk), .press(press), .pull_oe(ext_pull));

  // clock generator
  always #5 mclk = ~mclk;

  // regular timer servicing
  // services enabled timers every quarter tick; also cuts a hang short
  always @(posedge mclk) begin
    cyc_cnt <= cyc_cnt + 1;
    timer_service <= (cyc_cnt % 50 == 0) ? svc_en : 3'h0;
    if (cyc_cnt == LIMIT) begin
      n_mismatch++;
      give_verdict();
    end
  end

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // waits for line release, boot pulse and core start
  task automatic recover();
    int t0;
    int i;
    t0 = -1;
    for (i = 0; i < 3000; i++) begin
      @(posedge mclk);
      #1;
      if (boot_start === 1'b1 && t0 < 0) begin
        t0 = i;
        chk("boot_addr", boot_addr, BOOT_ADDR);
      end
      if (core_run === 1'b1) break;
    end
    chk("core_run", 16'(core_run), 16'h1);
    chk("wake_delay", 16'(t0 >= 0 && i - t0 >= 999 && i - t0 <= 1002), 16'h1);
  endtask

  // counts cycles that the device pulls the wire low
  task automatic pulse_len(output int n);
    int i;
    n = 0;
    for (i = 0; i < 10 && reset_line_n_oe !== 1'b1; i++) begin
      @(posedge mclk);
      #1;
    end
    while (reset_line_n_oe === 1'b1 && n < 200) begin
      n++;
      @(posedge mclk);
      #1;
    end
  endtask

  // common judgement of a device-driven reset pulse
  task automatic reset_seen(input logic [2:0] cause, input string what);
    int n;
    #1;
    chk("core_halt", 16'(core_halt), 16'h1);
    chk("io_hiz", 16'(io_hiz), 16'h1);
    chk("mem_hiz", 16'(mem_hiz), 16'h1);
    chk("svc_pullup", 16'(service_pullup_en), 16'h1);
    chk(what, 16'(reset_cause), 16'(cause));
    pulse_len(n);
    chk("pulse_len", 16'(n), 16'(PULSE));
    recover();
  endtask

  task automatic sc_factor();
    logic [2:0] code [6] = '{FAC_HALF, FAC_X1, FAC_X2, FAC_X4, FAC_X8, 3'h7};
    logic [3:0] mult [6] = '{MULT_1, MULT_1, MULT_2, MULT_4, MULT_8, MULT_1};
    logic       slot_a;
    int         k;
    for (k = 0; k < 6; k++) begin
      @(posedge mclk);
      clk_factor <= code[k];
      repeat (3) @(posedge mclk);
      #1;
      chk("pll_mult", 16'(pll_mult), 16'(mult[k]));
      chk("pll_enable", 16'(pll_enable), 16'(k >= 2 && k <= 4));
      chk("app_half", 16'(app_half), 16'(k == 0));
      slot_a = app_slot;
      @(posedge mclk);
      #1;
      chk("app_slot", 16'(app_slot), (k == 0) ? {15'h0, ~slot_a} : 16'h1);
    end
  endtask

  task automatic sc_sw();
    @(posedge mclk);
    sw_reset_req <= 1'b1;
    @(posedge mclk);
    sw_reset_req <= 1'b0;
    reset_seen(CAUSE_SW, "sw_cause");
  endtask

  task automatic sc_trap();
    @(posedge mclk);
    trap_code <= 4'hA;
    trap_req <= 1'b1;
    @(posedge mclk);
    trap_req <= 1'b0;
    #1;
    chk("trap_irq", 16'(trap_irq), 16'h1);
    chk("trap_log", 16'(trap_log_code), 16'h000A);
    chk("trap_valid", 16'(trap_log_valid), 16'h1);
    @(posedge mclk);
    #1;
    chk("trap_irq_end", 16'(trap_irq), 16'h0);
    chk("trap_no_rst", 16'(reset_line_n_oe), 16'h0);
    @(posedge mclk);
    trap_code <= 4'h5;
    trap_req <= 1'b1;
    trap_reset_needed <= 1'b1;
    @(posedge mclk);
    trap_req <= 1'b0;
    trap_reset_needed <= 1'b0;
    reset_seen(CAUSE_TRAP, "trap_cause");
  endtask

  task automatic sc_timer();
    int   i;
    logic seen;
    seen = 1'b0;
    for (i = 0; i < 3 * TICK; i++) begin
      @(posedge mclk);
      #1;
      seen = seen | reset_line_n_oe;
    end
    chk("no_expiry", 16'(seen), 16'h0);
    @(posedge mclk);
    svc_en <= 3'h5;
    clk_factor <= FAC_X8; // tick period must not follow the factor
    for (i = 0; i < 2 * TICK + 10 && reset_line_n_oe !== 1'b1; i++) begin
      @(posedge mclk);
      #1;
    end
    chk("expiry_time", 16'(i < 2 * TICK + 10), 16'h1);
    chk("expiry_min", 16'(i > TICK), 16'h1);
    svc_en <= 3'h7;
    reset_seen(CAUSE_TIMER, "timer_cause");
    chk("expired", 16'(timer_expired), 16'h0002);
  endtask

  task automatic sc_ext();
    @(posedge mclk);
    service_drive <= 1'b1;
    press <= 1'b1;
    @(posedge mclk);
    press <= 1'b0;
    repeat (4) @(posedge mclk);
    #1;
    chk("ext_halt", 16'(core_halt), 16'h1);
    chk("ext_cause", 16'(reset_cause), 16'(CAUSE_EXT));
    chk("ext_no_drive", 16'(reset_line_n_oe), 16'h0);
    chk("ext_svc_oe", 16'(service_line_n_oe), 16'h0);
    chk("ext_pullup", 16'(service_pullup_en), 16'h1);
    chk("osc_run", 16'(osc_run), 16'h1);
    recover();
    @(posedge mclk);
    #1;
    chk("svc_drive", 16'(service_line_n_oe), 16'h1);
    chk("io_live", 16'(io_hiz), 16'h0);
    @(posedge mclk);
    service_drive <= 1'b0;
  endtask

  task automatic sc_lvd();
    @(posedge mclk);
    low_voltage_detector <= 1'b1;
    repeat (30) @(posedge mclk);
    #1;
    chk("lvd_drive", 16'(reset_line_n_oe), 16'h1);
    chk("lvd_cause", 16'(reset_cause), 16'(CAUSE_POR_LVD));
    chk("lvd_halt", 16'(core_halt), 16'h1);
    @(posedge mclk);
    low_voltage_detector <= 1'b0;
    recover();
  endtask

  // main sequence: reset state, then each scenario in turn
  initial begin
    repeat (3) @(posedge mclk);
    srst <= 1'b0;
    #1;
    chk("rst_drive", 16'(reset_line_n_oe), 16'h1);
    chk("rst_level", 16'(reset_line_n_o), 16'h0);
    chk("rst_halt", 16'(core_halt), 16'h1);
    chk("rst_io", 16'(io_hiz), 16'h1);
    chk("rst_mem", 16'(mem_hiz), 16'h1);
    chk("rst_pullup", 16'(service_pullup_en), 16'h1);
    chk("rst_cause", 16'(reset_cause), 16'(CAUSE_POR_LVD));
    recover();
    sc_factor();
    sc_sw();
    sc_trap();
    sc_timer();
    sc_ext();
    sc_lvd();
    give_verdict();
  end
endmodule
